// ==== src/eeprom_pkg.sv ====
`default_nettype none

package eeprom_pkg;

  localparam int          ADDR_W        = 11;
  localparam int          MEM_DEPTH     = 2048;
  localparam int          TIMER_W       = 18;
  localparam logic [3:0]  DEV_ID        = 4'hA;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  BIT_ONE       = 4'h1;
  localparam logic [10:0] ADDR_ONE      = 11'h001;

  localparam logic [2:0]  DENSITY_1K    = 3'h0;
  localparam logic [2:0]  DENSITY_2K    = 3'h1;
  localparam logic [2:0]  DENSITY_4K    = 3'h2;
  localparam logic [2:0]  DENSITY_8K    = 3'h3;
  localparam logic [2:0]  DENSITY_16K   = 3'h4;

  localparam logic [10:0] MASK_1K       = 11'h07F;
  localparam logic [10:0] MASK_2K       = 11'h0FF;
  localparam logic [10:0] MASK_4K       = 11'h1FF;
  localparam logic [10:0] MASK_8K       = 11'h3FF;
  localparam logic [10:0] MASK_16K      = 11'h7FF;
  localparam logic [10:0] PAGE8_MASK    = 11'h007;
  localparam logic [10:0] PAGE16_MASK   = 11'h00F;

  localparam logic [2:0]  SEL_ALL       = 3'h7;
  localparam logic [2:0]  SEL_HI2       = 3'h6;
  localparam logic [2:0]  SEL_HI1       = 3'h4;
  localparam logic [2:0]  SEL_NONE      = 3'h0;

  // Idle bus: clock and data high, select pins low
  localparam logic [4:0]  LINE_RESET    = 5'h18;

  localparam int          CORE_CLK_MHZ  = 50;
  localparam int          INTERNAL_WRITE_TIME_US = 5000;
  localparam int          WRITE_CYCLES  = INTERNAL_WRITE_TIME_US * CORE_CLK_MHZ;
  localparam logic [17:0] TIMER_RESET   = 18'h0_0000;
  localparam logic [17:0] TIMER_ONE     = 18'h0_0001;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_DEV       = 9'h002,
    ST_DEV_ACK   = 9'h004,
    ST_WADDR     = 9'h008,
    ST_WADDR_ACK = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } xfer_state_t;

  function automatic logic [10:0] array_mask(input logic [2:0] density);
    logic [10:0] m;
    unique case (density)
      DENSITY_1K: m = MASK_1K;
      DENSITY_2K: m = MASK_2K;
      DENSITY_4K: m = MASK_4K;
      DENSITY_8K: m = MASK_8K;
      default:    m = MASK_16K;
    endcase
    return m;
  endfunction

  function automatic logic [10:0] page_mask(input logic [2:0] density);
    return (density == DENSITY_1K || density == DENSITY_2K) ?
           PAGE8_MASK : PAGE16_MASK;
  endfunction

  function automatic logic [2:0] select_mask(input logic [2:0] density);
    logic [2:0] m;
    unique case (density)
      DENSITY_1K,
      DENSITY_2K: m = SEL_ALL;
      DENSITY_4K: m = SEL_HI2;
      DENSITY_8K: m = SEL_HI1;
      default:    m = SEL_NONE;
    endcase
    return m;
  endfunction

  function automatic logic dev_match(input logic [7:0] word,
                                     input logic [2:0] density,
                                     input logic [2:0] pins);
    return (word[7:4] == DEV_ID) &&
           (((word[3:1] ^ pins) & select_mask(density)) == 3'h0);
  endfunction

endpackage

`default_nettype wire

// ==== src/eeprom_ifs.sv ====
`timescale 1ns/1ns
`default_nettype none

interface link_events_if;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       sda;
  logic [2:0] cs_pins;
  modport source (output scl_rise, scl_fall, start, stop, sda, cs_pins);
  modport sink   (input  scl_rise, scl_fall, start, stop, sda, cs_pins);
endinterface

interface mem_port_if;
  logic        we;
  logic [10:0] waddr;
  logic [7:0]  wdata;
  logic [10:0] raddr;
  logic [7:0]  rdata;
  modport ctrl  (output we, waddr, wdata, raddr, input rdata);
  modport array (input we, waddr, wdata, raddr, output rdata);
endinterface

`default_nettype wire

// ==== src/line_sampler.sv ====
`timescale 1ns/1ns
`default_nettype none

module line_sampler import eeprom_pkg::*; (
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [2:0] i_cs_pins,
  link_events_if.source   ev
);

  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] sync;
    logic       scl_prev;
    logic       sda_prev;
  } sampler_t;

  sampler_t st;
  sampler_t next_st;

  always_comb begin
    next_st          = st;
    next_st.meta     = {i_scl, i_sda, i_cs_pins};
    next_st.sync     = st.meta;
    next_st.scl_prev = st.sync[4];
    next_st.sda_prev = st.sync[3];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st <= '{meta: LINE_RESET, sync: LINE_RESET, scl_prev: 1'b1,
              sda_prev: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign ev.scl_rise = st.sync[4] & ~st.scl_prev;
  assign ev.scl_fall = ~st.sync[4] & st.scl_prev;
  assign ev.start    = st.sync[4] & st.scl_prev
                     & st.sda_prev & ~st.sync[3];
  assign ev.stop     = st.sync[4] & st.scl_prev
                     & ~st.sda_prev & st.sync[3];
  assign ev.sda      = st.sync[3];
  assign ev.cs_pins  = st.sync[2:0];

endmodule

`default_nettype wire

// ==== src/eeprom_array.sv ====
`timescale 1ns/1ns
`default_nettype none

module eeprom_array import eeprom_pkg::*; (
  input  wire logic i_core_clk,
  mem_port_if.array mp
);

  // Stored data survives reset, as a nonvolatile array would
  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] cells;
  } array_t;

  array_t st;
  array_t next_st;

  always_comb begin
    next_st = st;
    if (mp.we) begin
      next_st.cells[mp.waddr] = mp.wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    st <= next_st;
  end

  assign mp.rdata = st.cells[mp.raddr];

endmodule

`default_nettype wire

// ==== src/serial_eeprom_slave.sv ====
`timescale 1ns/1ns
`default_nettype none

module serial_eeprom_slave import eeprom_pkg::*; #(
  parameter logic [2:0]  DENSITY           = DENSITY_2K,
  parameter int unsigned WRITE_CYCLE_COUNT = WRITE_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_chip_select_bit_high,
  input  wire logic i_chip_select_bit_mid,
  input  wire logic i_chip_select_bit_low,
  output var  logic o_sda_out,
  output var  logic o_sda_oe,
  output var  logic o_write_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    xfer_state_t        state;
    logic [3:0]         bit_cnt;
    logic [7:0]         shift;
    logic [10:0]        addr;
    logic [2:0]         page_sel;
    logic               dev_read;
    logic               wrote;
    logic               host_ack;
    logic               busy;
    logic [TIMER_W-1:0] timer;
    logic               mem_we;
    logic [10:0]        mem_waddr;
    logic [7:0]         mem_wdata;
    logic               sda_oe;
    logic               sda_out;
  } core_t;

  localparam logic [TIMER_W-1:0] TIMER_LOAD =
    TIMER_W'(WRITE_CYCLE_COUNT - 1);

  core_t         st;
  core_t         next_st;
  link_events_if ev ();
  mem_port_if    mp ();

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling and storage

  line_sampler u_sampler (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_cs_pins  ({i_chip_select_bit_high, i_chip_select_bit_mid,
                  i_chip_select_bit_low}),
    .ev         (ev)
  );

  eeprom_array u_array (
    .i_core_clk (i_core_clk),
    .mp         (mp)
  );

  assign mp.we    = st.mem_we;
  assign mp.waddr = st.mem_waddr;
  assign mp.wdata = st.mem_wdata;
  assign mp.raddr = st.addr;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine

  always_comb begin
    next_st         = st;
    next_st.mem_we  = 1'b0;
    next_st.sda_out = 1'b0;

    if (st.busy) begin
      // Internal write: bus events are not looked at
      next_st.state  = ST_IDLE;
      next_st.sda_oe = 1'b0;
      if (st.timer == TIMER_RESET) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.timer = st.timer - TIMER_ONE;
      end
    end else if (ev.stop) begin
      next_st.state  = ST_IDLE;
      next_st.sda_oe = 1'b0;
      if (st.wrote) begin
        next_st.busy  = 1'b1;
        next_st.timer = TIMER_LOAD;
        next_st.wrote = 1'b0;
      end
    end else if (ev.start) begin
      next_st.state   = ST_DEV;
      next_st.bit_cnt = 4'h0;
      next_st.sda_oe  = 1'b0;
    end else begin
      if (ev.scl_rise && st.state inside {ST_DEV, ST_WADDR, ST_WDATA,
                                          ST_RDATA}) begin
        next_st.bit_cnt = st.bit_cnt + BIT_ONE;
        if (st.state != ST_RDATA) begin
          next_st.shift = {st.shift[6:0], ev.sda};
        end
      end

      unique case (st.state)
        ST_IDLE: begin
          next_st.sda_oe = 1'b0;
        end

        ST_DEV: begin
          if (ev.scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
            next_st.bit_cnt = 4'h0;
            if (dev_match(st.shift, DENSITY, ev.cs_pins)) begin
              next_st.state    = ST_DEV_ACK;
              next_st.sda_oe   = 1'b1;
              next_st.dev_read = st.shift[0];
              if (!st.shift[0]) begin
                next_st.page_sel = st.shift[3:1];
              end
            end else begin
              next_st.state = ST_IDLE;
            end
          end
        end

        ST_DEV_ACK: begin
          if (ev.scl_fall) begin
            next_st.bit_cnt = 4'h0;
            if (st.dev_read) begin
              next_st.state  = ST_RDATA;
              next_st.shift  = mp.rdata;
              next_st.sda_oe = ~mp.rdata[7];
            end else begin
              next_st.state  = ST_WADDR;
              next_st.sda_oe = 1'b0;
            end
          end
        end

        ST_WADDR: begin
          if (ev.scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
            next_st.addr    = {st.page_sel, st.shift}
                            & array_mask(DENSITY);
            next_st.state   = ST_WADDR_ACK;
            next_st.sda_oe  = 1'b1;
            next_st.bit_cnt = 4'h0;
          end
        end

        ST_WADDR_ACK: begin
          if (ev.scl_fall) begin
            next_st.state  = ST_WDATA;
            next_st.sda_oe = 1'b0;
          end
        end

        ST_WDATA: begin
          if (ev.scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
            next_st.mem_we    = 1'b1;
            next_st.mem_waddr = st.addr;
            next_st.mem_wdata = st.shift;
            next_st.addr      = (st.addr & ~page_mask(DENSITY))
                              | ((st.addr + ADDR_ONE)
                                 & page_mask(DENSITY));
            next_st.wrote     = 1'b1;
            next_st.state     = ST_WDATA_ACK;
            next_st.sda_oe    = 1'b1;
            next_st.bit_cnt   = 4'h0;
          end
        end

        ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            next_st.state  = ST_WDATA;
            next_st.sda_oe = 1'b0;
          end
        end

        ST_RDATA: begin
          if (ev.scl_fall) begin
            if (st.bit_cnt == BITS_PER_BYTE) begin
              next_st.sda_oe  = 1'b0;
              next_st.addr    = (st.addr + ADDR_ONE)
                              & array_mask(DENSITY);
              next_st.state   = ST_RACK;
              next_st.bit_cnt = 4'h0;
            end else begin
              next_st.sda_oe = ~st.shift[6];
              next_st.shift  = {st.shift[6:0], 1'b0};
            end
          end
        end

        ST_RACK: begin
          if (ev.scl_rise) begin
            next_st.host_ack = ~ev.sda;
          end
          if (ev.scl_fall) begin
            if (st.host_ack) begin
              next_st.state   = ST_RDATA;
              next_st.shift   = mp.rdata;
              next_st.sda_oe  = ~mp.rdata[7];
              next_st.bit_cnt = 4'h0;
            end else begin
              next_st.state = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st <= '{state: ST_IDLE, bit_cnt: 4'h0, shift: 8'h00,
              addr: 11'h000, page_sel: 3'h0, dev_read: 1'b0,
              wrote: 1'b0, host_ack: 1'b0, busy: 1'b0,
              timer: TIMER_RESET, mem_we: 1'b0, mem_waddr: 11'h000,
              mem_wdata: 8'h00, sda_oe: 1'b0, sda_out: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_sda_out    = st.sda_out;
  assign o_sda_oe     = st.sda_oe;
  assign o_write_busy = st.busy;

endmodule

`default_nettype wire

// ==== bench/eeprom_link_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none

module eeprom_link_monitor import eeprom_pkg::*; #(
  parameter logic [2:0]  DENSITY           = DENSITY_2K,
  parameter int unsigned WRITE_CYCLE_COUNT = WRITE_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_chip_select_bit_high,
  input  wire logic i_chip_select_bit_mid,
  input  wire logic i_chip_select_bit_low,
  input  wire logic o_sda_out,
  input  wire logic o_sda_oe,
  input  wire logic o_write_busy
);
  logic        scl_q, sda_q, first, st_busy;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  int unsigned busy_cnt;
  wire logic [2:0] sel_mask = (DENSITY <= DENSITY_2K) ? 3'h7 :
    (DENSITY == DENSITY_4K) ? 3'h6 : (DENSITY == DENSITY_8K) ? 3'h4 : 3'h0;
  wire logic       ack_slot = first && (bit_cnt == 4'h8);
  wire logic       bad = (shreg[7:4] != 4'hA) || (((shreg[3:1] ^
    {i_chip_select_bit_high, i_chip_select_bit_mid, i_chip_select_bit_low})
    & sel_mask) != 3'h0);

  ////////////////////////////////////////
  // Bit tracker seen from the pins
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      first    <= 1'b0;
      st_busy  <= 1'b0;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      busy_cnt <= '0;
    end else begin
      scl_q    <= i_scl;
      sda_q    <= i_sda;
      busy_cnt <= o_write_busy ? busy_cnt + 1 : '0;
      if (scl_q && i_scl && sda_q && !i_sda) begin
        first   <= 1'b1;
        st_busy <= o_write_busy;
        bit_cnt <= 4'h0;
      end else if (!scl_q && i_scl) begin
        shreg   <= {shreg[6:0], i_sda};
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
        if (bit_cnt == 4'h8) begin
          first <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  property p_drive_low; o_sda_oe |-> !o_sda_out; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data line driven high");
  property p_oe_scl_low; $changed(o_sda_oe) |-> !$past(i_scl, 2); endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data changed while clock high");
  property p_ack_hold; $rose(o_sda_oe) |-> o_sda_oe [*6]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("driven bit too short");
  property p_quiet_busy; o_write_busy |-> !o_sda_oe; endproperty
  a_quiet_busy: assert property (p_quiet_busy)
    else $error("answer during internal write");
  property p_busy_idle; $rose(o_write_busy) |-> i_scl && i_sda; endproperty
  a_busy_idle: assert property (p_busy_idle)
    else $error("internal write without stop");
  property p_busy_len;
    $fell(o_write_busy) |-> busy_cnt == WRITE_CYCLE_COUNT;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("internal write length wrong");
  property p_no_match; ack_slot && bad |-> !o_sda_oe; endproperty
  a_no_match: assert property (p_no_match)
    else $error("acknowledge on foreign address");
  property p_match;
    $rose(ack_slot) && !bad && !st_busy && !o_write_busy |-> ##[1:12] o_sda_oe;
  endproperty
  a_match: assert property (p_match)
    else $error("missing acknowledge");
endmodule

bind serial_eeprom_slave eeprom_link_monitor #(
  .DENSITY          (DENSITY),
  .WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)
) u_eeprom_link_monitor (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda),
  .i_chip_select_bit_high(i_chip_select_bit_high),
  .i_chip_select_bit_mid(i_chip_select_bit_mid),
  .i_chip_select_bit_low(i_chip_select_bit_low),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_write_busy(o_write_busy)
);

`default_nettype wire

// ==== bench/eeprom_bus_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

module eeprom_bus_ctrl (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_pull
);
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end

  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // Data moves only in the clock low half
  task automatic put(input logic d, output logic q);
    tick(2);
    o_sda_pull <= ~d;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    q = i_sda;
    tick(2);
    o_scl <= 1'b0;
  endtask

  task automatic start;
    tick(2);
    o_sda_pull <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_pull <= 1'b1;
    tick(4);
    o_scl <= 1'b0;
  endtask

  task automatic stop;
    tick(2);
    o_sda_pull <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_pull <= 1'b0;
    tick(8);
  endtask

  // Eight bits first MSB, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic nak,
                      output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put(d[i], q[i]);
    end
    put(nak, b);
    ack = ~b;
  endtask
endmodule

`default_nettype wire

// ==== bench/serial_eeprom_slave_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module serial_eeprom_slave_bench import eeprom_pkg::*; ;
  logic       core_clk  = 1'b0;
  logic       nrst      = 1'b0;
  logic [2:0] cs        = 3'h5;
  // Low select pin of the 4K part and low two of the 8K part are unused
  logic [2:0] cs4       = 3'h7;
  logic [2:0] cs8       = 3'h3;
  logic       scl, pull, oe, sda_out, busy;
  logic       oe4, sda_out4, busy4, oe8, sda_out8, busy8;
  wire logic  sda_line;
  int         n_errors  = 0;
  int         cmp_count = 0;
  int         cycles    = 0;
  logic [7:0] got [0:15];

  // Open-drain wire with pull-up
  assign sda_line = ~pull & ~(oe & ~sda_out) & ~(oe4 & ~sda_out4)
                  & ~(oe8 & ~sda_out8);
  always #10 core_clk = ~core_clk;

  serial_eeprom_slave #(
    .DENSITY          (DENSITY_2K),
    .WRITE_CYCLE_COUNT(20)
  ) u_serial_eeprom_slave (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda_line),
    .i_chip_select_bit_high(cs[2]), .i_chip_select_bit_mid(cs[1]),
    .i_chip_select_bit_low(cs[0]), .o_sda_out(sda_out), .o_sda_oe(oe),
    .o_write_busy(busy)
  );

  serial_eeprom_slave #(
    .DENSITY          (DENSITY_4K),
    .WRITE_CYCLE_COUNT(20)
  ) u_serial_eeprom_slave_4k (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda_line),
    .i_chip_select_bit_high(cs4[2]), .i_chip_select_bit_mid(cs4[1]),
    .i_chip_select_bit_low(cs4[0]), .o_sda_out(sda_out4), .o_sda_oe(oe4),
    .o_write_busy(busy4)
  );

  serial_eeprom_slave #(
    .DENSITY          (DENSITY_8K),
    .WRITE_CYCLE_COUNT(20)
  ) u_serial_eeprom_slave_8k (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda_line),
    .i_chip_select_bit_high(cs8[2]), .i_chip_select_bit_mid(cs8[1]),
    .i_chip_select_bit_low(cs8[0]), .o_sda_out(sda_out8), .o_sda_oe(oe8),
    .o_write_busy(busy8)
  );

  eeprom_bus_ctrl u_eeprom_bus_ctrl (
    .i_core_clk(core_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(pull)
  );

  ////////////////////////////////////////
  task automatic results;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic dev(input logic [7:0] w, output logic a);
    logic [7:0] q;
    u_eeprom_bus_ctrl.start();
    u_eeprom_bus_ctrl.xfer(w, 1'b1, q, a);
  endtask

  task automatic write_seq(input logic [7:0] dw, input logic [7:0] addr,
                           input logic [7:0] base, input int n);
    logic       a;
    logic [7:0] q;
    logic [2:0] who;
    // Busy flag expected on the addressed part only
    who = !dw[3] ? 3'h4 : (dw[2] ? 3'h2 : 3'h1);
    dev(dw, a);
    check({7'h00, a}, 8'h01);
    u_eeprom_bus_ctrl.xfer(addr, 1'b1, q, a);
    check({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_eeprom_bus_ctrl.xfer(base + 8'(i), 1'b1, q, a);
      check({7'h00, a}, 8'h01);
    end
    u_eeprom_bus_ctrl.stop();
    check({5'h00, busy8, busy4, busy}, {5'h00, who});
    dev(dw, a);
    check({7'h00, a}, 8'h00);
    u_eeprom_bus_ctrl.stop();
    dev(dw, a);
    check({7'h00, a}, 8'h01);
    u_eeprom_bus_ctrl.stop();
  endtask

  task automatic read_seq(input logic [7:0] dw, input logic [7:0] addr,
                          input logic rnd, input int n);
    logic       a;
    logic [7:0] q;
    if (rnd) begin
      dev(dw, a);
      u_eeprom_bus_ctrl.xfer(addr, 1'b1, q, a);
      check({7'h00, a}, 8'h01);
    end
    dev(dw | 8'h01, a);
    check({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_eeprom_bus_ctrl.xfer(8'hFF, i == n - 1, got[i], a);
    end
    u_eeprom_bus_ctrl.stop();
  endtask

  ////////////////////////////////////////
  task automatic t_byte_write;
    write_seq(8'hAA, 8'h10, 8'h5A, 1);
    read_seq(8'hAA, 8'h10, 1'b1, 1);
    check(got[0], 8'h5A);
  endtask

  task automatic t_page_wrap;
    write_seq(8'hAA, 8'h1E, 8'h30, 9);
    read_seq(8'hAA, 8'h18, 1'b1, 8);
    for (int i = 0; i < 7; i++) begin
      check(got[i], 8'h32 + 8'(i));
    end
    check(got[7], 8'h31);
  endtask

  task automatic t_array_wrap;
    write_seq(8'hAA, 8'hFF, 8'hC3, 1);
    write_seq(8'hAA, 8'h00, 8'h11, 2);
    read_seq(8'hAA, 8'hFF, 1'b1, 2);
    check(got[0], 8'hC3);
    check(got[1], 8'h11);
    read_seq(8'hAA, 8'h00, 1'b0, 1);
    check(got[0], 8'h12);
  endtask

  task automatic t_mismatch;
    logic a;
    cs <= 3'h4;
    repeat (4) @(posedge core_clk);
    dev(8'hAA, a);
    check({7'h00, a}, 8'h00);
    u_eeprom_bus_ctrl.stop();
    cs <= 3'h5;
    dev(8'h5A, a);
    check({7'h00, a}, 8'h00);
    u_eeprom_bus_ctrl.stop();
    read_seq(8'hAA, 8'h10, 1'b1, 1);
    check(got[0], 8'h5A);
  endtask

  // Parts with page bits in the device word
  task automatic t_density;
    write_seq(8'hAE, 8'h05, 8'h77, 1);
    write_seq(8'hAC, 8'h05, 8'h66, 1);
    read_seq(8'hAE, 8'h05, 1'b1, 1);
    check(got[0], 8'h77);
    read_seq(8'hAC, 8'h05, 1'b1, 1);
    check(got[0], 8'h66);
    write_seq(8'hA4, 8'h3E, 8'h40, 3);
    write_seq(8'hA2, 8'h3E, 8'h50, 1);
    read_seq(8'hA4, 8'h3E, 1'b1, 2);
    check(got[0], 8'h40);
    check(got[1], 8'h41);
    read_seq(8'hA4, 8'h30, 1'b1, 1);
    check(got[0], 8'h42);
    read_seq(8'hA2, 8'h3E, 1'b1, 1);
    check(got[0], 8'h50);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_byte_write();
    t_page_wrap();
    t_array_wrap();
    t_mismatch();
    t_density();
    results();
  end
endmodule

`default_nettype wire
